// ==== hw/pfs_sequencer.sv ====
// Notes on behaviour
// - pickup command: fast motor plus clutch together
// - after fast interval, drop to printer speed
// - feed command: fast motor, roller carries sheet
// - after fast interval, feed at printer speed
// - upper feeders obey feed commands for passage
// - jam if sensor misses edge in window
// - on jam stop motor, clutch; report
// - optional 1.2 s tail run after registration
// - sensor sampled at programmed sequence points
// - option-select chain passed to next feeder
// - motion only on commands; status always readable
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`include "pfs_regs.svh"
`default_nettype none
module pfs_sequencer #(
  parameter int TAIL_CYC = `PFS_TAIL_MS * (`PFS_CLK_HZ / 1000),
  parameter logic [15:0] FAST_DIV = 16'h0010,
  parameter logic [15:0] SLOW_DIV = 16'h0020
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic feedPathSensor,
  input wire logic optionSelectChainInN,
  output logic optionSelectChainOutN,
  output logic pickupMotorStep,
  output logic pickupMotorFast,
  output logic pickupClutch,
  output logic irq
);
  import pfs_pkg::*;
  localparam logic [23:0] TAIL_LAST = 24'(TAIL_CYC - 1);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  pfs_regs_t q, d; // registered state and its next value
  logic wrGo; // both write halves present
  logic [31:0] wMask; // byte-lane mask from strobes
  logic cmdPick, cmdFeed, cmdReg, cmdStop; // command pulses
  logic edgeSeen; // leading edge on the feed path sensor
  logic running; // motor is stepping
  logic [15:0] divLim; // half period of the step output
  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    d = q;
    wrGo = q.awHave && q.wHave && !q.bValid;
    wMask = {{8{q.wStrb[3]}}, {8{q.wStrb[2]}},
             {8{q.wStrb[1]}}, {8{q.wStrb[0]}}};
    cmdPick = 1'b0;
    cmdFeed = 1'b0;
    cmdReg = 1'b0;
    cmdStop = 1'b0;
    // motor stepping; set first because the status read uses it
    running = (q.st == S_FAST) || (q.st == S_SLOW) || (q.st == S_TAIL);
    // write channel capture, either order
    if (s_axi_awvalid && q.awRdy) begin
      d.awHave = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wRdy) begin
      d.wHave = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    // register write, then response
    if (wrGo) begin
      d.awHave = 1'b0;
      d.wHave = 1'b0;
      d.bValid = 1'b1;
      d.bResp = RESP_OK;
      unique case (q.awAddr)
        `PFS_CTRL: begin
          // commands are single pulses from the low byte
          if (q.wStrb[0]) begin
            cmdPick = q.wData[`PFS_CMD_PICK];
            cmdFeed = q.wData[`PFS_CMD_FEED];
            cmdReg = q.wData[`PFS_CMD_REG];
            cmdStop = q.wData[`PFS_CMD_STOP];
            d.tailEn = q.wData[`PFS_CTL_TAIL];
          end
        end
        `PFS_STATUS: ; // read only, write ignored
        `PFS_IRQ_STAT: begin
          // write one to clear
          d.irqSt = q.irqSt & ~(q.wData[2:0] & wMask[2:0]);
        end
        `PFS_IRQ_MASK: begin
          d.irqMask = (q.irqMask & ~wMask[2:0]) | (q.wData[2:0] & wMask[2:0]);
        end
        `PFS_HS_CYC: begin
          // programmable fast interval
          d.hsLim = (q.hsLim & ~wMask[15:0]) |
                    (q.wData[15:0] & wMask[15:0]);
        end
        `PFS_JAM_CYC: begin
          // programmable jam window
          d.jamLim = (q.jamLim & ~wMask[15:0]) |
                     (q.wData[15:0] & wMask[15:0]);
        end
        default: d.bResp = RESP_ERR; // unmapped
      endcase
    end
    // read channel
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (s_axi_arvalid && q.arRdy) begin
      d.rValid = 1'b1;
      d.rResp = RESP_OK;
      unique case (s_axi_araddr)
        `PFS_CTRL: d.rData = {27'h0, q.tailEn, 4'h0};
        // live state of the sequencer for the host
        `PFS_STATUS: d.rData = {22'h0, q.st, q.seen, feedPathSensor,
                                q.clutch, q.fast, running};
        `PFS_IRQ_STAT: d.rData = {29'h0, q.irqSt};
        `PFS_IRQ_MASK: d.rData = {29'h0, q.irqMask};
        `PFS_HS_CYC: d.rData = {16'h0, q.hsLim};
        `PFS_JAM_CYC: d.rData = {16'h0, q.jamLim};
        default: begin
          d.rData = 32'h0;
          d.rResp = RESP_ERR;
        end
      endcase
    end
    d.awRdy = !d.awHave && !d.bValid;
    d.wRdy = !d.wHave && !d.bValid;
    d.arRdy = !d.rValid;
    // feed path sensor edge, only looked at while running
    d.sensPrev = feedPathSensor;
    edgeSeen = feedPathSensor && !q.sensPrev;
    // sequencer: no motion without a command
    unique case (q.st)
      S_IDLE: begin
        if (cmdPick || cmdFeed) begin
          // a feed command also serves sheets from lower units
          d.st = S_FAST;
          d.clutch = cmdPick;
          d.hsCnt = 16'h0;
          d.jamCnt = 16'h0;
          d.seen = 1'b0;
        end
      end
      S_FAST, S_SLOW: begin
        d.hsCnt = q.hsCnt + 16'h1;
        if (!q.seen) begin
          d.jamCnt = q.jamCnt + 16'h1;
        end
        if (edgeSeen) begin
          d.seen = 1'b1;
        end
        if (q.st == S_FAST && q.hsCnt >= q.hsLim) begin
          d.st = S_SLOW;
          d.clutch = 1'b0;
        end
        if (q.st == S_SLOW && cmdReg) begin
          // tail run lets a long sheet clear the roller
          d.st = q.tailEn ? S_TAIL : S_IDLE;
          d.tailCnt = 24'h0;
        end
        // missed leading edge at the end of the window
        if (!q.seen && !edgeSeen && q.jamCnt >= q.jamLim) begin
          d.st = S_JAM;
          d.clutch = 1'b0;
        end
      end
      S_TAIL: begin
        d.tailCnt = q.tailCnt + 24'h1;
        if (q.tailCnt >= TAIL_LAST) begin
          d.st = S_IDLE;
        end
      end
      S_JAM: begin
        d.clutch = 1'b0; // held off until stopped
      end
      default: d.st = S_IDLE; // illegal code recovers
    endcase
    if (cmdStop && q.st != S_IDLE) begin
      d.st = S_IDLE;
      d.clutch = 1'b0;
    end
    // step generator: half period picks the speed
    divLim = (q.st == S_FAST) ? FAST_DIV : SLOW_DIV;
    d.fast = (d.st == S_FAST);
    if (!running) begin
      d.divCnt = 16'h0;
      d.step = 1'b0;
    end else if (q.divCnt >= divLim - 16'h1) begin
      d.divCnt = 16'h0;
      d.step = !q.step;
    end else begin
      d.divCnt = q.divCnt + 16'h1;
    end
    // sticky events, set wins over a clear in the same cycle
    if (d.st == S_JAM && q.st != S_JAM) begin
      d.irqSt[`PFS_IRQ_JAM] = 1'b1;
    end
    if (d.st == S_IDLE && (q.st == S_SLOW || q.st == S_TAIL)) begin
      d.irqSt[`PFS_IRQ_DONE] = 1'b1;
    end
    if (running && edgeSeen) begin
      d.irqSt[`PFS_IRQ_EDGE] = 1'b1;
    end
    d.irq = |(d.irqSt & d.irqMask);
    // pass the select chain one stage on
    d.chainOutN = optionSelectChainInN;
  end
  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= S_IDLE;
      q.hsLim <= `PFS_HS_RST;
      q.jamLim <= `PFS_JAM_RST;
      q.awRdy <= 1'b1;
      q.wRdy <= 1'b1;
      q.arRdy <= 1'b1;
      q.chainOutN <= 1'b1;
      q.sensPrev <= 1'b0;
    end else begin
      q <= d;
    end
  end
  // outputs straight from the state register
  assign s_axi_awready = q.awRdy;
  assign s_axi_wready = q.wRdy;
  assign s_axi_bvalid = q.bValid;
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = q.arRdy;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rdata = q.rData;
  assign s_axi_rresp = q.rResp;
  assign pickupMotorStep = q.step;
  assign pickupMotorFast = q.fast;
  assign pickupClutch = q.clutch;
  assign optionSelectChainOutN = q.chainOutN;
  assign irq = q.irq;
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  sequence pickTaken;
    q.st == S_IDLE && cmdPick;
  endsequence
  sequence fastDone;
    q.st == S_FAST && q.hsCnt >= q.hsLim && !cmdStop &&
      !(!q.seen && !edgeSeen && q.jamCnt >= q.jamLim);
  endsequence
  a_pick_clutch_on: assert property (
      pickTaken |=> q.clutch && q.fast)
    else $error("pickup did not start fast with clutch");
  a_fast_to_slow: assert property (
      fastDone |=> q.st == S_SLOW && !q.fast)
    else $error("fast interval did not end");
  a_feed_no_clutch: assert property (
      q.st == S_IDLE && cmdFeed && !cmdPick |=> q.st == S_FAST && !q.clutch)
    else $error("feed command started wrongly");
  a_slow_speed_on: assert property (
      $rose(q.st == S_SLOW) |-> !q.fast ##1 (q.st != S_FAST))
    else $error("slow feed speed not held");
  a_jam_window: assert property (
      running && !q.seen && !edgeSeen && q.jamCnt >= q.jamLim &&
      q.st != S_TAIL |=> q.st == S_JAM)
    else $error("missed edge not flagged as jam");
  a_jam_halts: assert property (
      q.st == S_JAM |-> !q.clutch ##1 (!pickupMotorStep && !pickupClutch))
    else $error("motor or clutch active in jam");
  a_jam_irq: assert property (
      $rose(q.st == S_JAM) |-> q.irqSt[`PFS_IRQ_JAM])
    else $error("jam not reported");
  a_tail_length: assert property (
      $rose(q.st == S_TAIL) && !cmdStop |-> q.tailCnt == 24'h0)
    else $error("tail run did not start from zero");
  // a tail that overstays its count would break this bound
  a_tail_bound: assert property (
      q.st == S_TAIL |-> q.tailCnt <= TAIL_LAST)
    else $error("tail run overran its length");
  a_idle_still: assert property (
      q.st == S_IDLE && !cmdPick && !cmdFeed
      |=> !pickupClutch && !pickupMotorStep)
    else $error("motion without a command");
  a_chain_pass: assert property (
      1'b1 |=> optionSelectChainOutN == $past(optionSelectChainInN))
    else $error("select chain not passed on");
endmodule : pfs_sequencer
`default_nettype wire

// ==== hw/pfs_regs.svh ====
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define PFS_CTRL 5'h00
`define PFS_STATUS 5'h04
`define PFS_IRQ_STAT 5'h08
`define PFS_IRQ_MASK 5'h0C
`define PFS_HS_CYC 5'h10
`define PFS_JAM_CYC 5'h14
// ****************************************************************
// field positions
// ****************************************************************
`define PFS_CMD_PICK 0
`define PFS_CMD_FEED 1
`define PFS_CMD_REG 2
`define PFS_CMD_STOP 3
`define PFS_CTL_TAIL 4
`define PFS_IRQ_JAM 0
`define PFS_IRQ_DONE 1
`define PFS_IRQ_EDGE 2
// ****************************************************************
// reset values and timing
// ****************************************************************
`define PFS_HS_RST 16'h03E8
`define PFS_JAM_RST 16'h2710
`define PFS_TAIL_MS 1200
`define PFS_CLK_HZ 10000000
`endif

// ==== hw/pfs_pkg.sv ====
`default_nettype none
// ****************************************************************
// types shared by the sequencer
// ****************************************************************
package pfs_pkg;
  // one-hot sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_FAST = 5'h02,
    S_SLOW = 5'h04,
    S_TAIL = 5'h08,
    S_JAM = 5'h10
  } pfs_state_t;
  // complete state of the sequencer
  typedef struct packed {
    pfs_state_t st;
    logic awHave;
    logic [4:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awRdy;
    logic wRdy;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic tailEn;
    logic [15:0] hsLim;
    logic [15:0] jamLim;
    logic [15:0] hsCnt;
    logic [15:0] jamCnt;
    logic [23:0] tailCnt;
    logic [15:0] divCnt;
    logic seen;
    logic sensPrev;
    logic step;
    logic fast;
    logic clutch;
    logic chainOutN;
    logic [2:0] irqSt;
    logic [2:0] irqMask;
    logic irq;
  } pfs_regs_t;
endpackage : pfs_pkg
`default_nettype wire

// ==== tb/pfs_paper_model.sv ====
`default_nettype none
// ****************************************************************
// paper path seen by the feed path sensor
// ****************************************************************
module pfs_paper_model #(
  parameter int DLY = 30,
  parameter int LEN = 40
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic motorStep,
  input wire logic noPaper,
  output logic sensor
);
  timeunit 1ns;
  timeprecision 1ns;
  int idleCnt_q; // cycles since the last step pulse
  int runCnt_q; // cycles since the roller started
  // a sheet covers the sensor some cycles after the roller starts;
  // the step half period is below 40, so 40 quiet cycles mean stopped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idleCnt_q <= 100;
      runCnt_q <= 0;
      sensor <= 1'b0;
    end else begin
      idleCnt_q <= motorStep ? 0 : (idleCnt_q < 100 ? idleCnt_q + 1 : 100);
      if (idleCnt_q >= 40 && !motorStep) begin
        runCnt_q <= 0;
      end else if (runCnt_q < 1000) begin
        runCnt_q <= runCnt_q + 1;
      end
      // empty cassette: the sensor never sees a leading edge
      sensor <= !noPaper && runCnt_q >= DLY && runCnt_q < DLY + LEN;
    end
  end
endmodule : pfs_paper_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`include "pfs_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pfs_pkg::*;
  localparam int HS = 20; // short fast phase for the run
  localparam int JAM = 100; // short jam window for the run
  logic sys_clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sens, chainIn;
  logic chainOut, step, fast, clutch, irq, noPaper;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, b;
  int errors, checkCount;
  pfs_sequencer #(.TAIL_CYC(50)) pfs_sequencer_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .feedPathSensor(sens),
    .optionSelectChainInN(chainIn), .optionSelectChainOutN(chainOut),
    .pickupMotorStep(step), .pickupMotorFast(fast),
    .pickupClutch(clutch), .irq(irq));
  pfs_paper_model pfs_paper_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .motorStep(step), .noPaper(noPaper), .sensor(sens));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // write: both channels offered together, each dropped when taken
  task automatic axw(input logic [4:0] a, input logic [31:0] v);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    b = bresp;
    chk("write done", 1, n < 100);
  endtask : axw
  task automatic axr(input logic [4:0] a);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    chk("read done", 1, n < 100);
  endtask : axr
  task automatic finish_test();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    int n;
    n = 0;
    repeat (50) begin
      @(posedge sys_clk);
      if (step !== 1'b0) begin
        n++;
      end
    end
    chk("idle step", 0, n);
    axr(`PFS_HS_CYC);
    chk("fast count reset", `PFS_HS_RST, d);
    axr(`PFS_JAM_CYC);
    chk("jam count reset", `PFS_JAM_RST, d);
    axr(5'h1C);
    chk("unmapped resp", 2, r);
    chk("unmapped data", 0, d);
    axw(5'h1C, 32'h0);
    chk("unmapped wresp", 2, b);
    axw(`PFS_HS_CYC, HS);
    chk("write resp", 0, b);
    axw(`PFS_JAM_CYC, JAM);
    axr(`PFS_HS_CYC);
    chk("fast count", HS, d);
    axr(`PFS_JAM_CYC);
    chk("jam count", JAM, d);
    axw(`PFS_IRQ_MASK, 32'h1);
  endtask : t_reset
  // the select chain is how the host numbers stacked feeders
  task automatic t_chain();
    chainIn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("chain low", 0, chainOut);
    chainIn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("chain high", 1, chainOut);
  endtask : t_chain
  // pickup (clutch on) or feed (clutch off), then registration
  task automatic run_seq(input logic [31:0] c, input logic cl, input logic t);
    int n;
    repeat (60) @(posedge sys_clk);
    axw(`PFS_CTRL, c | {27'h0, t, 4'h0});
    chk("fast at start", 1, fast);
    chk("clutch", cl, clutch);
    n = 0;
    while (fast === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    // fast phase stands for the programmed count plus one clock
    chk("fast span", HS + 1, n);
    chk("clutch off slow", 0, clutch);
    repeat (60) @(posedge sys_clk);
    axr(`PFS_STATUS);
    chk("slow state", 5'h04, d[9:5]);
    chk("running", 1, d[0]);
    chk("edge seen", 1, d[4]);
    // registration only follows our leading edge, as the host does
    axw(`PFS_CTRL, 32'h4 | {27'h0, t, 4'h0});
    axr(`PFS_STATUS);
    chk("after reg", t ? 5'h08 : 5'h01, d[9:5]);
    if (t) begin
      repeat (30) @(posedge sys_clk);
      axr(`PFS_STATUS);
      chk("tail still", 5'h08, d[9:5]);
      repeat (30) @(posedge sys_clk);
      axr(`PFS_STATUS);
      chk("tail end", 5'h01, d[9:5]);
    end
    // done and sensor edge flags set, both masked off the irq pin
    axr(`PFS_IRQ_STAT);
    chk("sequence flags", 32'h6, d);
    chk("irq masked", 0, irq);
    axw(`PFS_IRQ_STAT, 32'h6);
  endtask : run_seq
  task automatic t_jam();
    axw(`PFS_IRQ_STAT, 32'h7);
    noPaper <= 1'b1;
    axw(`PFS_CTRL, 32'h1);
    repeat (60) @(posedge sys_clk);
    axr(`PFS_STATUS);
    chk("no early jam", 5'h04, d[9:5]);
    repeat (60) @(posedge sys_clk);
    axr(`PFS_STATUS);
    chk("jam state", 5'h10, d[9:5]);
    chk("jam step", 0, step);
    chk("jam clutch", 0, clutch);
    chk("jam irq", 1, irq);
    axr(`PFS_IRQ_STAT);
    chk("jam flag", 1, d[0]);
    axw(`PFS_CTRL, 32'h8);
    axw(`PFS_IRQ_STAT, 32'h1);
    axr(`PFS_IRQ_STAT);
    chk("jam flag clear", 0, d[0]);
    chk("irq clear", 0, irq);
    axr(`PFS_STATUS);
    chk("stopped", 5'h01, d[9:5]);
    noPaper <= 1'b0;
  endtask : t_jam
  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // the whole run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("wrong value watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    arst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    chainIn = 1'b1;
    noPaper = 1'b0;
    errors = 0;
    checkCount = 0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_chain();
    run_seq(32'h1, 1'b1, 1'b1);
    run_seq(32'h2, 1'b0, 1'b0);
    t_jam();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
